// *** bps_bridge_model.sv ***
// bps_bridge_model: power bridge gate lines as seen from the stage's pins
// assumes bridge_pins of bps_bridge_pwm; every gate line has a pull-down
`timescale 1ns/100ps
module bps_bridge_model (
    input wire bps_pkg::bps_pins_t bridge_pins,
    output logic [3:0] pin_lvl
);
    import bps_pkg::*;

    // ----------------------------------------
    // wire level
    // ----------------------------------------
    // a released gate line falls to its pull-down
    assign pin_lvl = bridge_pins.oe & bridge_pins.drive;
endmodule : bps_bridge_model

// *** bps_bridge_pwm.sv ***
// bps_bridge_pwm: multi-output pwm stage with dead band, direction hand-over and auto-shutdown
// assumes the period timer and duty comparator on clk_sys; comparator and fault inputs are asynchronous
//
// Function
// - half-bridge: A is pwm, B its complement
// - dead band delays inactive-to-active by instruction cycles
// - dead band beyond duty keeps output inactive
// - forward: A active, D modulated, B C off
// - reverse: C active, B modulated, A D off
// - direction bit takes effect next pwm cycle
// - unmodulated pins switch one tick before end
// - modulated pins inactive until next period starts
// - full-bridge never applies dead band
// - shutdown only in enhanced modes, three triggers
// - source field selects comparators and fault pin
// - shutdown forces pins without waiting for period
// - A/C shutdown: low, high or tri-state
// - B/D shutdown: low, high or tri-state
// - status bit set by hardware, holds shutdown
// - restart enable selects software or automatic clear
// - status writes ignored while cause present
// - status set at period start holds whole period
// - normal output resumes at next period start
// - dead band and shutdown registers eight bits, mode register two, all reset zero
// - dead band loads at duty or period edge
// - comparator cause blocks clearing as a level
// - writing one to status forces shutdown
`timescale 1ns/100ps
module bps_bridge_pwm (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [bps_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire bps_pkg::bps_timer_t timer_evt,
    input wire logic comp1_out,
    input wire logic comp2_out,
    input wire logic fault_input_pin_n,
    output bps_pkg::bps_pins_t bridge_pins
);
    import bps_pkg::*;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic src_hit(input logic [2:0] sel, input logic c1, input logic c2, input logic flt);
        src_hit = (sel[0] & c1) | (sel[1] & c2) | (sel[2] & flt);
    endfunction : src_hit

    function automatic logic [1:0] pair_level(input logic [1:0] code);
        pair_level = {~code[1], code == SSTATE_HIGH};
    endfunction : pair_level

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] dbrc_q;
    logic [6:0] asc_cfg_q;
    logic [1:0] pmc_q;
    logic status_q;
    logic status_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] div_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] trig_q;
    bps_cfg_t mode_q;
    logic turn_q;
    logic [6:0] db_q;
    logic [1:0] sched_q;
    logic [1:0] done_q;
    logic [6:0] cnt_q [2];
    logic hold_q;
    bps_pins_t pins_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire bus_req = avs_read | avs_write;
    wire take = bus_req & ~ack_q;
    wire commit = bus_req & ack_q;
    wire wr_dbrc = commit & avs_write & (avs_address == ADDR_DBRC);
    wire wr_asc = commit & avs_write & (avs_address == ADDR_ASC);
    wire wr_pmc = commit & avs_write & (avs_address == ADDR_PMC);
    wire ic_en = (div_q == INSTR_LAST);
    wire [2:0] src_sel = asc_cfg_q[SRC_MSB:SRC_LSB];
    wire enhanced = (mode_q != CFG_SINGLE);
    wire cause = enhanced & src_hit(src_sel, trig_q[0], trig_q[1], ~trig_q[2]);
    wire sw_set = wr_asc & avs_writedata[ASC_STATUS_BIT];
    wire sw_clr = wr_asc & ~avs_writedata[ASC_STATUS_BIT] & ~cause;
    wire auto_clr = dbrc_q[DBRC_RESTART_BIT] & ~cause;
    wire shut_now = enhanced & (cause | status_q | hold_q);
    wire [7:0] asc_read = {status_q, asc_cfg_q};
    wire [31:0] rdata_d = (avs_address == ADDR_DBRC) ? {24'h0, dbrc_q} :
                          (avs_address == ADDR_ASC) ? {24'h0, asc_read} :
                          (avs_address == ADDR_PMC) ? {30'h0, pmc_q} : 32'h0;

    assign avs_waitrequest = bus_req & ~ack_q;
    assign avs_readdata = rdata_q;
    assign bridge_pins = pins_q;

    always_ff @(posedge clk_sys)
    begin
        ack_q <= srst ? 1'b0 : take;
        rdata_q <= srst ? 32'h0 : ((take & avs_read) ? rdata_d : rdata_q);
        div_q <= srst ? 2'h0 : div_q + 2'h1;
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dbrc_q <= DBRC_RESET;
            asc_cfg_q <= ASC_RESET[6:0];
            pmc_q <= PMC_RESET;
        end
        else
        begin
            if (wr_dbrc)
                dbrc_q <= avs_writedata[7:0];
            if (wr_asc)
                asc_cfg_q <= avs_writedata[6:0];
            if (wr_pmc)
                pmc_q <= avs_writedata[1:0];
        end
    end

    // ----------------------------------------
    // shutdown status, set wins over clear
    // ----------------------------------------
    always_comb
    begin
        status_d = status_q;
        if (sw_clr | auto_clr)
            status_d = 1'b0;
        if (cause | sw_set)
            status_d = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            status_q <= ASC_RESET[ASC_STATUS_BIT];
            hold_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            if (status_q)
                hold_q <= 1'b1;
            else if (timer_evt.period_start)
                hold_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // trigger synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            sync3_q <= 3'h4;
            trig_q <= 3'h4;
        end
        else
        begin
            sync1_q <= {fault_input_pin_n, comp2_out, comp1_out};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 3; i++)
                if (sync2_q[i] == sync3_q[i])
                    trig_q[i] <= sync3_q[i];
        end
    end

    // ----------------------------------------
    // mode, direction and dead band loading
    // ----------------------------------------
    wire new_full = pmc_q[0];
    wire [6:0] db_cfg = dbrc_q[DB_MSB:0];
    wire [6:0] db_now = (timer_evt.period_start | timer_evt.duty_match) ? db_cfg : db_q;
    wire dir_change = (mode_q == CFG_FULL_FWD || mode_q == CFG_FULL_REV) && new_full && (pmc_q[1] != mode_q[1]);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode_q <= CFG_SINGLE;
            turn_q <= 1'b0;
            db_q <= DBRC_RESET[DB_MSB:0];
        end
        else
        begin
            if (timer_evt.period_start)
            begin
                mode_q <= bps_cfg_t'(pmc_q);
                turn_q <= 1'b0;
            end
            else if (timer_evt.period_last_tick && dir_change)
                turn_q <= 1'b1;
            if (timer_evt.period_start | timer_evt.duty_match)
                db_q <= db_cfg;
        end
    end

    // ----------------------------------------
    // dead band for half-bridge
    // ----------------------------------------
    wire [1:0] sched = {~timer_evt.pwm_raw, timer_evt.pwm_raw};
    logic [1:0] gated;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
            gated[i] = sched[i] & ((db_now == 7'h0) | done_q[i]);
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sched_q <= 2'h0;
            done_q <= 2'h0;
            cnt_q[0] <= 7'h0;
            cnt_q[1] <= 7'h0;
        end
        else
        begin
            sched_q <= sched;
            for (int i = 0; i < 2; i++)
            begin
                if (sched[i] & ~sched_q[i])
                begin
                    cnt_q[i] <= db_now;
                    done_q[i] <= (db_now == 7'h0);
                end
                else if (~sched[i])
                    done_q[i] <= 1'b0;
                else if (ic_en & ~done_q[i])
                begin
                    cnt_q[i] <= cnt_q[i] - 7'h1;
                    done_q[i] <= (cnt_q[i] <= 7'h1);
                end
            end
        end
    end

    // ----------------------------------------
    // output selection
    // ----------------------------------------
    wire rev_now = turn_q ? pmc_q[1] : mode_q[1];
    wire pwm = timer_evt.pwm_raw;
    wire [3:0] drv_half = {2'b00, gated[1], gated[0]};
    wire [3:0] drv_full = rev_now ? {1'b0, 1'b1, pwm & ~turn_q, 1'b0} :
                                    {pwm & ~turn_q, 1'b0, 1'b0, 1'b1};
    wire [3:0] drv_norm = (mode_q == CFG_HALF) ? drv_half :
                          (mode_q == CFG_SINGLE) ? {3'b000, pwm} : drv_full;
    wire [3:0] oe_norm = (mode_q == CFG_SINGLE) ? 4'h1 : (mode_q == CFG_HALF) ? 4'h3 : 4'hf;
    wire [1:0] lvl_ac = pair_level(asc_cfg_q[PAIR_AC_MSB:PAIR_AC_LSB]);
    wire [1:0] lvl_bd = pair_level(asc_cfg_q[PAIR_BD_MSB:PAIR_BD_LSB]);
    wire [3:0] drv_shut = {lvl_bd[0], lvl_ac[0], lvl_bd[0], lvl_ac[0]};
    wire [3:0] oe_shut = {lvl_bd[1], lvl_ac[1], lvl_bd[1], lvl_ac[1]};

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            pins_q <= '0;
        else if (shut_now)
            pins_q <= {drv_shut & oe_shut, oe_shut};
        else
            pins_q <= {drv_norm, oe_norm};
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_half_comp: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_HALF && !shut_now && db_now == 7'h0) |=>
        (pins_q.drive[PIN_A] == $past(pwm)) && (pins_q.drive[PIN_B] == !$past(pwm)))
        else $error("half-bridge outputs not complementary");

    a_db_delay: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_HALF && $rose(pwm) && db_now != 7'h0) |=> !pins_q.drive[PIN_A])
        else $error("dead band not applied to rising edge");

    a_full_fwd: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_FULL_FWD && !turn_q && !shut_now) |=>
        (pins_q.drive == {$past(pwm), 3'b001}))
        else $error("forward pattern wrong");

    a_full_rev: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_FULL_REV && !turn_q && !shut_now) |=>
        (pins_q.drive == {2'b01, $past(pwm), 1'b0}))
        else $error("reverse pattern wrong");

    a_turn_mod: assert property (@(posedge clk_sys) disable iff (srst)
        (turn_q && !shut_now) |=> (!pins_q.drive[PIN_B] && !pins_q.drive[PIN_D]))
        else $error("modulated pin active during hand-over");

    a_turn_start: assert property (@(posedge clk_sys) disable iff (srst)
        (timer_evt.period_last_tick && !timer_evt.period_start && dir_change) |=> turn_q)
        else $error("direction hand-over not started");

    a_shut_pins: assert property (@(posedge clk_sys) disable iff (srst)
        shut_now |=> (pins_q.oe == $past(oe_shut)) && (pins_q.drive == $past(drv_shut & oe_shut)))
        else $error("pins not in shutdown state");

    a_status_set: assert property (@(posedge clk_sys) disable iff (srst)
        (cause || sw_set) |=> status_q)
        else $error("status not set by shutdown event");

    a_status_keep: assert property (@(posedge clk_sys) disable iff (srst)
        (status_q && cause) |=> status_q)
        else $error("status cleared while cause present");

    a_hold_period: assert property (@(posedge clk_sys) disable iff (srst)
        (status_q && timer_evt.period_start) |=> hold_q)
        else $error("shutdown not held for the period");

    a_single_oe: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_SINGLE && !srst) |=> (pins_q.oe == 4'h1))
        else $error("single mode output enables wrong");

    a_fault_src: assert property (@(posedge clk_sys) disable iff (srst)
        (enhanced && src_sel[2] && !trig_q[2]) |=> status_q)
        else $error("fault pin did not set status");

    a_cmp_level: assert property (@(posedge clk_sys) disable iff (srst)
        (enhanced && src_sel[0] && trig_q[0]) |=> status_q)
        else $error("comparator level did not hold status");

    a_auto_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (dbrc_q[DBRC_RESTART_BIT] && status_q && !cause && !sw_set) |=> !status_q)
        else $error("automatic restart did not clear status");

    a_sw_hold: assert property (@(posedge clk_sys) disable iff (srst)
        (!dbrc_q[DBRC_RESTART_BIT] && status_q && !sw_clr) |=> status_q)
        else $error("status cleared without software");

    a_sw_ignore: assert property (@(posedge clk_sys) disable iff (srst)
        (cause && wr_asc) |=> status_q)
        else $error("status write taken while cause present");

    a_resume_hold: assert property (@(posedge clk_sys) disable iff (srst)
        (enhanced && hold_q) |=> (pins_q.oe == $past(oe_shut)))
        else $error("output resumed before period start");

    a_full_nodb: assert property (@(posedge clk_sys) disable iff (srst)
        (mode_q == CFG_FULL_FWD && !turn_q && !shut_now && $rose(pwm)) |=> pins_q.drive[PIN_D])
        else $error("full-bridge modulated edge delayed");

    a_db_load: assert property (@(posedge clk_sys) disable iff (srst)
        (timer_evt.period_start || timer_evt.duty_match) |=> (db_q == $past(db_cfg)))
        else $error("dead band not loaded at boundary");

    a_tri_bd: assert property (@(posedge clk_sys) disable iff (srst)
        (shut_now && asc_cfg_q[PAIR_BD_MSB]) |=> (!pins_q.oe[PIN_B] && !pins_q.oe[PIN_D]))
        else $error("b/d pins driven in tri-state shutdown");

    a_turn_clear: assert property (@(posedge clk_sys) disable iff (srst)
        timer_evt.period_start |=> !turn_q)
        else $error("hand-over not ended at period start");

    a_mode_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !timer_evt.period_start |=> $stable(mode_q))
        else $error("mode changed inside a period");

endmodule : bps_bridge_pwm

// *** bps_bridge_pwm_tb.sv ***
// bps_bridge_pwm_tb: register, bridge mode and shutdown tests
// assumes a bench-made period timer of 40 clocks, duty 16, prescale 1
`timescale 1ns/100ps
module bps_bridge_pwm_tb;
    import bps_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int PER = 40;
    localparam int DUTY = 16;
    logic clk_sys;
    logic srst;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic avs_waitrequest;
    bps_timer_t timer_evt;
    logic comp1_out;
    logic comp2_out;
    logic fault_input_pin_n;
    bps_pins_t bridge_pins;
    logic [3:0] pin_lvl;
    int cnt = 0;
    int cyc = 0;
    int n_mismatch = 0;
    int total_checks = 0;

    bps_bridge_pwm i_bps_bridge_pwm (
        .clk_sys(clk_sys),
        .srst(srst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .timer_evt(timer_evt),
        .comp1_out(comp1_out),
        .comp2_out(comp2_out),
        .fault_input_pin_n(fault_input_pin_n),
        .bridge_pins(bridge_pins)
    );

    bps_bridge_model i_bps_bridge_model (
        .bridge_pins(bridge_pins),
        .pin_lvl(pin_lvl)
    );

    // ----------------------------------------
    // clock, period timer, timeout
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    assign timer_evt = '{cnt < DUTY, cnt == 0, cnt == DUTY, cnt == PER - 4};

    always @(posedge clk_sys)
    begin
        cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20)
            n_mismatch++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdx(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdx

    task automatic at_cnt(input int k);
        do
            @(negedge clk_sys);
        while (cnt != k);
    endtask : at_cnt

    task automatic test_done;
        $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        srst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        comp1_out = 1'b0;
        comp2_out = 1'b0;
        fault_input_pin_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        rdx(ADDR_DBRC, 32'h0);
        rdx(ADDR_ASC, 32'h0);
        rdx(4'hc, 32'h0);
        wr(ADDR_DBRC, 32'h85);
        rdx(ADDR_DBRC, 32'h85);
        // single output mode never shuts down
        wr(ADDR_ASC, 32'h40);
        fault_input_pin_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rdx(ADDR_ASC, 32'h40);
        fault_input_pin_n <= 1'b1;
        wr(ADDR_ASC, 32'h0);
        // half bridge, dead band 5 then 2
        wr(ADDR_PMC, 32'h2);
        at_cnt(PER - 1);
        at_cnt(15);
        chk(32'(pin_lvl[1:0]), 32'h0);
        wr(ADDR_DBRC, 32'h02);
        at_cnt(PER - 1);
        at_cnt(5);
        chk(32'(pin_lvl[1:0]), 32'h0);
        at_cnt(15);
        chk(32'(pin_lvl[1:0]), 32'h1);
        at_cnt(21);
        chk(32'(pin_lvl[1:0]), 32'h0);
        at_cnt(34);
        chk(32'(pin_lvl[1:0]), 32'h2);
        // full bridge forward, then reverse written mid period
        wr(ADDR_PMC, 32'h1);
        at_cnt(PER - 1);
        at_cnt(5);
        chk(32'(pin_lvl), 32'h9);
        at_cnt(30);
        chk(32'(pin_lvl), 32'h1);
        wr(ADDR_PMC, 32'h3);
        at_cnt(34);
        chk(32'(pin_lvl), 32'h1);
        at_cnt(39);
        chk(32'(pin_lvl), 32'h4);
        at_cnt(5);
        chk(32'(pin_lvl), 32'h6);
        at_cnt(30);
        chk(32'(pin_lvl), 32'h4);
        // fault pin shutdown, software restart
        wr(ADDR_ASC, 32'h46);
        fault_input_pin_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk(32'(bridge_pins.oe), 32'h5);
        chk(32'(pin_lvl), 32'h5);
        rdx(ADDR_ASC, 32'hc6);
        wr(ADDR_ASC, 32'h46);
        rdx(ADDR_ASC, 32'hc6);
        fault_input_pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rdx(ADDR_ASC, 32'hc6);
        at_cnt(20);
        wr(ADDR_ASC, 32'h46);
        rdx(ADDR_ASC, 32'h46);
        chk(32'(bridge_pins.oe), 32'h5);
        at_cnt(15);
        chk(32'(pin_lvl), 32'h6);
        // shutdown forced by software
        at_cnt(20);
        wr(ADDR_ASC, 32'h81);
        repeat (3) @(posedge clk_sys);
        chk(32'(bridge_pins.oe), 32'hf);
        chk(32'(pin_lvl), 32'ha);
        at_cnt(15);
        chk(32'(pin_lvl), 32'ha);
        wr(ADDR_ASC, 32'h01);
        // every source code against every trigger, automatic restart
        wr(ADDR_DBRC, 32'h80);
        for (int s = 0; s < 8; s++)
            for (int t = 0; t < 3; t++)
            begin
                wr(ADDR_ASC, 32'(s) << 4);
                comp1_out <= (t == 0);
                comp2_out <= (t == 1);
                fault_input_pin_n <= (t != 2);
                repeat (8) @(posedge clk_sys);
                bus(1'b0, ADDR_ASC, 32'h0);
                chk(32'(rd[7]), 32'(s[t]));
                comp1_out <= 1'b0;
                comp2_out <= 1'b0;
                fault_input_pin_n <= 1'b1;
                repeat (8) @(posedge clk_sys);
                rdx(ADDR_ASC, 32'(s) << 4);
            end
        // half bridge with zero dead band passes edges through
        wr(ADDR_PMC, 32'h2);
        at_cnt(PER - 1);
        at_cnt(5);
        chk(32'(pin_lvl), 32'h1);
        at_cnt(20);
        chk(32'(pin_lvl), 32'h2);
        test_done();
    end
endmodule : bps_bridge_pwm_tb

// *** bps_pkg.sv ***
// bps_pkg: constants, types and register layout for the bridge pwm shutdown stage
// assumes a single 40 MHz system clock equal to the oscillator period
package bps_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_DBRC = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ASC = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PMC = 4'h8;
    localparam logic [7:0] DBRC_RESET = 8'h00;
    localparam logic [7:0] ASC_RESET = 8'h00;
    localparam logic [1:0] PMC_RESET = 2'h0;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int DBRC_RESTART_BIT = 7;
    localparam int DB_MSB = 6;
    localparam int ASC_STATUS_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 4;
    localparam int PAIR_AC_MSB = 3;
    localparam int PAIR_AC_LSB = 2;
    localparam int PAIR_BD_MSB = 1;
    localparam int PAIR_BD_LSB = 0;

    // ----------------------------------------
    // output pin indices and shutdown codes
    // ----------------------------------------
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam logic [1:0] SSTATE_LOW = 2'h0;
    localparam logic [1:0] SSTATE_HIGH = 2'h1;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int TOSC_NS = 25;
    localparam int INSTR_NS = 4 * TOSC_NS;
    localparam int INSTR_CLKS = (INSTR_NS + TOSC_NS - 1) / TOSC_NS;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

    typedef enum logic [1:0] {
        CFG_SINGLE = 2'h0,
        CFG_FULL_FWD = 2'h1,
        CFG_HALF = 2'h2,
        CFG_FULL_REV = 2'h3
    } bps_cfg_t;

    // events from the period timer and duty comparator
    typedef struct packed {
        logic pwm_raw;
        logic period_start;
        logic duty_match;
        logic period_last_tick;
    } bps_timer_t;

    // four bridge pins, drive level and output enable
    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] oe;
    } bps_pins_t;

endpackage : bps_pkg
